// ### inc/cfgms_pkg.sv
// types and the mode decode function of the configuration mode pin select block
`include "cfgms_regs.svh"

package cfgms_pkg;

  typedef enum logic [6:0] {
    CFGMS_MSERIAL  = 7'h01,
    CFGMS_MFLASHS  = 7'h02,
    CFGMS_MPFLASH  = 7'h04,
    CFGMS_MPPORT   = 7'h08,
    CFGMS_SCANONLY = 7'h10,
    CFGMS_SPPORT   = 7'h20,
    CFGMS_SSERIAL  = 7'h40
  } cfgms_mode_t;

  typedef logic [`CFGMS_B0_N-1:0]  cfgms_b0_t;
  typedef logic [`CFGMS_B65_N-1:0] cfgms_b65_t;

  // three-bit pin code to interface; the unlisted code 011 selects no interface pins
  function automatic cfgms_mode_t cfgms_decode(input logic [2:0] code);
    case (code)
      `CFGMS_CODE_MSERIAL:  cfgms_decode = CFGMS_MSERIAL;
      `CFGMS_CODE_MFLASHS:  cfgms_decode = CFGMS_MFLASHS;
      `CFGMS_CODE_MPFLASH:  cfgms_decode = CFGMS_MPFLASH;
      `CFGMS_CODE_MPPORT:   cfgms_decode = CFGMS_MPPORT;
      `CFGMS_CODE_SPPORT:   cfgms_decode = CFGMS_SPPORT;
      `CFGMS_CODE_SSERIAL:  cfgms_decode = CFGMS_SSERIAL;
      default:              cfgms_decode = CFGMS_SCANONLY;
    endcase
  endfunction : cfgms_decode

endpackage : cfgms_pkg

// ### inc/cfgms_regs.svh
// constants for the configuration mode pin select block
`ifndef CFGMS_REGS_SVH
`define CFGMS_REGS_SVH

// mode pin codes
`define CFGMS_CODE_MSERIAL  3'h0
`define CFGMS_CODE_MFLASHS  3'h1
`define CFGMS_CODE_MPFLASH  3'h2
`define CFGMS_CODE_MPPORT   3'h4
`define CFGMS_CODE_SCANONLY 3'h5
`define CFGMS_CODE_SPPORT   3'h6
`define CFGMS_CODE_SSERIAL  3'h7
// value read when the mode pins float high
`define CFGMS_MODE_DEFAULT  3'h7

// bank 0 multi-use pin positions
`define CFGMS_B0_FCS        0
`define CFGMS_B0_D00        1
`define CFGMS_B0_D01        2
`define CFGMS_B0_D02        3
`define CFGMS_B0_D03        4
`define CFGMS_B0_N          5

// bank 65 pin group positions
`define CFGMS_B65_D07_04    0
`define CFGMS_B65_D15_08    1
`define CFGMS_B65_A15_D31   2
`define CFGMS_B65_A28_16    3
`define CFGMS_B65_EXTCLK    4
`define CFGMS_B65_CSI_ADV   5
`define CFGMS_B65_DOUT_CSO  6
`define CFGMS_B65_FOE       7
`define CFGMS_B65_FWE_FCS2  8
`define CFGMS_B65_RS        9
`define CFGMS_B65_N         10

// width select codes
`define CFGMS_WSEL_X1       2'h0
`define CFGMS_WSEL_X2       2'h1
`define CFGMS_WSEL_X4       2'h2
`define CFGMS_WSEL_X8       2'h3
`define CFGMS_PSEL_X8       2'h0
`define CFGMS_PSEL_X16      2'h1
`define CFGMS_PSEL_X32      2'h2

// internal configuration clock divider half period in CLK cycles
`define CFGMS_CLK_HALF_DEF  4

`endif

// ### logic/cfgms_mode_latch.sv
// synchroniser and one-shot capture of the mode select pins
`timescale 1ns/1ps
`default_nettype none
`include "cfgms_regs.svh"

module cfgms_mode_latch #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic             start,
  output logic      [WIDTH-1:0] code_q,
  output logic                  captured_q
);

  // ****************************************
  // checks
  // ****************************************
  initial begin
    if (WIDTH != 3) begin
      $error("mode latch supports exactly three mode pins");
    end
  end

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // capture once at the first start after reset, then hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_q     <= `CFGMS_MODE_DEFAULT;
      captured_q <= 1'b0;
    end else if (start && !captured_q) begin
      code_q     <= sync2_q;
      captured_q <= 1'b1;
    end
  end

  chk_capture_hold: assert property (@(posedge clk) disable iff (!rstn)
    captured_q |=> $stable(code_q) && captured_q)
    else $error("captured mode changed before reset");

endmodule : cfgms_mode_latch

`default_nettype wire

// ### logic/cfgms_pin_select.sv
// configuration mode pin select: mode decode, clock pin direction and pin usage
//
// Overview of operation
// - decode mode pins into seven interfaces: serial, flash, parallel, port, scan, slave port, slave serial
// - every master mode drives the configuration clock pin out
// - slave modes take the configuration clock pin as input from the source
// - boundary scan stays available whatever the mode pins read
// - floating mode pins read 111, so slave serial is the default
// - dedicated bank 0 pins take part in every configuration mode
// - bank 65 pins are configuration pins only in modes using them, otherwise user I/O
// - with keep option, used bank 65 pins keep configuration function after done
// - configuration pins unused by the mode are high impedance and ignored
// - daisy-chain data output driven only while forwarding serial data, else high impedance
// - external master clock used only when enabled, else internal configuration clock
`timescale 1ns/1ps
`default_nettype none
`include "cfgms_regs.svh"

module cfgms_pin_select #(
  parameter int CLK_HALF = `CFGMS_CLK_HALF_DEF
) (
  input  wire logic                     CLK,
  input  wire logic                     RSTN,
  input  wire logic [2:0]               MODE_PINS,
  input  wire logic                     CFG_START,
  input  wire logic [1:0]               WIDTH_SEL,
  input  wire logic                     CFG_DONE,
  input  wire logic                     KEEP_CFG_PINS,
  input  wire logic                     EXT_CLK_EN,
  input  wire logic                     EXTERNAL_MASTER_CLOCK_IN,
  input  wire logic                     CONFIG_CLOCK_PIN_I,
  output logic                          CONFIG_CLOCK_PIN_O,
  output logic                          CONFIG_CLOCK_PIN_OE,
  output logic                          CONFIG_CLOCK_LEVEL,
  input  wire logic                     DAISY_FWD,
  input  wire logic                     DAISY_DATA,
  output logic                          DAISY_OUT_O,
  output logic                          DAISY_OUT_OE,
  output logic [2:0]                    MODE_CODE,
  output logic [6:0]                    MODE_ONEHOT,
  output logic                          MODE_VALID,
  output logic                          IS_MASTER,
  output logic [5:0]                    BUS_LANES,
  output logic                          SCAN_AVAIL,
  output logic                          BANK0_DEDICATED_EN,
  output logic [`CFGMS_B0_N-1:0]        BANK0_CFG,
  output logic [`CFGMS_B65_N-1:0]       BANK65_CFG
);

  // ****************************************
  // parameter checks
  // ****************************************
  initial begin
    if (CLK_HALF < 1 || CLK_HALF > 255) begin
      $error("CLK_HALF must lie in 1..255");
    end
  end

  // ****************************************
  // mode capture and decode
  // ****************************************
  logic [2:0]          code;
  logic                captured;
  cfgms_pkg::cfgms_mode_t mode;
  cfgms_pkg::cfgms_b0_t   b0_use;
  cfgms_pkg::cfgms_b65_t  b65_use;
  logic                master;
  logic [5:0]          lanes;

  cfgms_mode_latch #(
    .WIDTH      (3)
  ) u_latch (
    .clk        (CLK),
    .rstn       (RSTN),
    .pins       (MODE_PINS),
    .start      (CFG_START),
    .code_q     (code),
    .captured_q (captured)
  );

  assign mode = cfgms_pkg::cfgms_decode(code);

  // pin usage and bus width per interface
  always_comb begin
    b0_use  = '0;
    b65_use = '0;
    lanes   = 6'h01;
    master  = 1'b0;
    case (mode)
      cfgms_pkg::CFGMS_MSERIAL: begin
        master = 1'b1;
        b0_use[`CFGMS_B0_D01]         = 1'b1;
        b65_use[`CFGMS_B65_EXTCLK]    = 1'b1;
        b65_use[`CFGMS_B65_DOUT_CSO]  = 1'b1;
      end
      cfgms_pkg::CFGMS_MFLASHS: begin
        master = 1'b1;
        b0_use[`CFGMS_B0_FCS]         = 1'b1;
        b0_use[`CFGMS_B0_D00]         = 1'b1;
        b0_use[`CFGMS_B0_D01]         = 1'b1;
        b65_use[`CFGMS_B65_EXTCLK]    = 1'b1;
        case (WIDTH_SEL)
          `CFGMS_WSEL_X1: begin
            b65_use[`CFGMS_B65_DOUT_CSO] = 1'b1;
          end
          `CFGMS_WSEL_X2: begin
            lanes = 6'h02;
          end
          `CFGMS_WSEL_X4: begin
            lanes = 6'h04;
            b0_use[`CFGMS_B0_D03:`CFGMS_B0_D02] = 2'h3;
          end
          default: begin
            lanes = 6'h08;
            b0_use[`CFGMS_B0_D03:`CFGMS_B0_D02] = 2'h3;
            b65_use[`CFGMS_B65_D07_04]   = 1'b1;
            b65_use[`CFGMS_B65_FWE_FCS2] = 1'b1;
          end
        endcase
      end
      cfgms_pkg::CFGMS_MPFLASH, cfgms_pkg::CFGMS_MPPORT, cfgms_pkg::CFGMS_SPPORT: begin
        master = (mode != cfgms_pkg::CFGMS_SPPORT);
        b0_use = '1;
        lanes  = 6'h08;
        b65_use[`CFGMS_B65_D07_04]    = 1'b1;
        b65_use[`CFGMS_B65_CSI_ADV]   = 1'b1;
        b65_use[`CFGMS_B65_DOUT_CSO]  = 1'b1;
        b65_use[`CFGMS_B65_EXTCLK]    = master;
        if (WIDTH_SEL != `CFGMS_PSEL_X8) begin
          lanes = 6'h10;
          b65_use[`CFGMS_B65_D15_08]  = 1'b1;
        end
        if (mode == cfgms_pkg::CFGMS_MPFLASH) begin
          b65_use[`CFGMS_B65_A15_D31] = 1'b1;
          b65_use[`CFGMS_B65_A28_16]  = 1'b1;
          b65_use[`CFGMS_B65_FOE]     = 1'b1;
          b65_use[`CFGMS_B65_FWE_FCS2] = 1'b1;
          b65_use[`CFGMS_B65_RS]      = 1'b1;
        end
        if (mode == cfgms_pkg::CFGMS_SPPORT && WIDTH_SEL == `CFGMS_PSEL_X32) begin
          lanes = 6'h20;
          b65_use[`CFGMS_B65_A15_D31] = 1'b1;
        end
      end
      cfgms_pkg::CFGMS_SSERIAL: begin
        b0_use[`CFGMS_B0_D01]         = 1'b1;
        b65_use[`CFGMS_B65_DOUT_CSO]  = 1'b1;
      end
      default: begin
        lanes = 6'h01;                              // scan only: no pins beyond bank 0 dedicated
      end
    endcase
  end

  // registered mode status
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODE_CODE   <= `CFGMS_MODE_DEFAULT;
      MODE_ONEHOT <= cfgms_pkg::CFGMS_SSERIAL;
      MODE_VALID  <= 1'b0;
      IS_MASTER   <= 1'b0;
      BUS_LANES   <= 6'h01;
    end else begin
      MODE_CODE   <= code;
      MODE_ONEHOT <= mode;
      MODE_VALID  <= captured;
      IS_MASTER   <= master && captured;
      BUS_LANES   <= lanes;
    end
  end

  // scan path and dedicated bank 0 never depend on the mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SCAN_AVAIL         <= 1'b0;
      BANK0_DEDICATED_EN <= 1'b0;
    end else begin
      SCAN_AVAIL         <= 1'b1;
      BANK0_DEDICATED_EN <= 1'b1;
    end
  end

  // ****************************************
  // configuration pin ownership
  // ****************************************
  logic cfg_phase;
  assign cfg_phase = captured && !CFG_DONE;

  // bank 0 multi-use pins: unused ones stay released
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      BANK0_CFG <= '0;
    end else begin
      BANK0_CFG <= b0_use & {`CFGMS_B0_N{cfg_phase}};
    end
  end

  // bank 65 groups: config function only when used, kept after done on request
  genvar g;
  generate
    for (g = 0; g < `CFGMS_B65_N; g++) begin : g_b65
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          BANK65_CFG[g] <= 1'b0;
        end else begin
          BANK65_CFG[g] <= b65_use[g] && captured && (!CFG_DONE || KEEP_CFG_PINS);
        end
      end
    end
  endgenerate

  // ****************************************
  // configuration clock
  // ****************************************
  logic [7:0] div_q;
  logic       int_clk_q;
  logic       ext_s1_q;
  logic       ext_s2_q;
  logic       cin_s1_q;
  logic       cin_s2_q;
  logic       use_ext;

  // internal configuration clock from CLK
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q     <= 8'h00;
      int_clk_q <= 1'b0;
    end else if (div_q == 8'(CLK_HALF - 1)) begin
      div_q     <= 8'h00;
      int_clk_q <= !int_clk_q;
    end else begin
      div_q     <= div_q + 8'h01;
    end
  end

  // pin synchronisers for the external clock and the received clock
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      cin_s1_q <= 1'b0;
      cin_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= EXTERNAL_MASTER_CLOCK_IN;
      ext_s2_q <= ext_s1_q;
      cin_s1_q <= CONFIG_CLOCK_PIN_I;
      cin_s2_q <= cin_s1_q;
    end
  end

  assign use_ext = EXT_CLK_EN && b65_use[`CFGMS_B65_EXTCLK];

  // direction and source of the clock pin
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CONFIG_CLOCK_PIN_O  <= 1'b0;
      CONFIG_CLOCK_PIN_OE <= 1'b0;
      CONFIG_CLOCK_LEVEL  <= 1'b0;
    end else begin
      CONFIG_CLOCK_PIN_O  <= use_ext ? ext_s2_q : int_clk_q;
      CONFIG_CLOCK_PIN_OE <= master && captured;
      CONFIG_CLOCK_LEVEL  <= CONFIG_CLOCK_PIN_OE ? CONFIG_CLOCK_PIN_O : cin_s2_q;
    end
  end

  // ****************************************
  // daisy-chain data output
  // ****************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DAISY_OUT_O  <= 1'b0;
      DAISY_OUT_OE <= 1'b0;
    end else begin
      DAISY_OUT_O  <= DAISY_FWD ? DAISY_DATA : 1'b0;
      DAISY_OUT_OE <= DAISY_FWD && cfg_phase && lanes == 6'h01
                      && b65_use[`CFGMS_B65_DOUT_CSO];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_decode_map: assert property (@(posedge CLK) disable iff (!RSTN)
    ##1 MODE_ONEHOT == $past(mode))
    else $error("mode one-hot does not match pin code");

  chk_master_clk_out: assert property (@(posedge CLK) disable iff (!RSTN)
    (captured && code inside {3'h0, 3'h1, 3'h2, 3'h4}) |=> CONFIG_CLOCK_PIN_OE)
    else $error("master mode not driving clock pin");

  chk_slave_clk_in: assert property (@(posedge CLK) disable iff (!RSTN)
    (code inside {3'h6, 3'h7}) |=> !CONFIG_CLOCK_PIN_OE)
    else $error("slave mode driving clock pin");

  chk_scan_always: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(RSTN) |-> SCAN_AVAIL && BANK0_DEDICATED_EN)
    else $error("scan path or bank 0 dropped");

  chk_default_slave: assert property (@(posedge CLK) disable iff (!RSTN)
    !captured |-> code == 3'h7 && !CONFIG_CLOCK_PIN_OE)
    else $error("default mode is not slave serial");

  chk_b65_user_io: assert property (@(posedge CLK) disable iff (!RSTN)
    (CFG_DONE && !KEEP_CFG_PINS) |=> BANK65_CFG == '0)
    else $error("bank 65 not returned to user after done");

  chk_keep_pins: assert property (@(posedge CLK) disable iff (!RSTN)
    (captured && CFG_DONE && KEEP_CFG_PINS) |=> BANK65_CFG == $past(b65_use))
    else $error("kept configuration pins lost after done");

  chk_unused_hiz: assert property (@(posedge CLK) disable iff (!RSTN)
    ##1 (BANK0_CFG & ~$past(b0_use)) == '0 && (BANK65_CFG & ~$past(b65_use)) == '0)
    else $error("unused configuration pin claimed");

  chk_daisy_hiz: assert property (@(posedge CLK) disable iff (!RSTN)
    (!DAISY_FWD || CFG_DONE) |=> !DAISY_OUT_OE)
    else $error("daisy output driven without forwarding");

  chk_int_clk_src: assert property (@(posedge CLK) disable iff (!RSTN)
    !EXT_CLK_EN |=> CONFIG_CLOCK_PIN_O == $past(int_clk_q))
    else $error("external clock used while disabled");

endmodule : cfgms_pin_select

`default_nettype wire

// ### verification/cfgms_board_model.sv
// board straps and configuration clock source facing the mode pin select block
`timescale 1ns/1ps
`default_nettype none
`include "cfgms_regs.svh"

module cfgms_board_model #(
  parameter bit MULTI_DIE = 1'b0
) (
  input  wire logic       strap_en,
  input  wire logic [2:0] strap_code,
  input  wire logic       src_clk,
  input  wire logic       pin_oe,
  input  wire logic       pin_o,
  output logic      [2:0] mode_pins,
  output logic            pin_level
);
  // ****************
  // straps and clock wire
  // ****************

  // a loose strap floats and the pull-ups make it read high
  always_comb begin
    if (!strap_en) begin
      mode_pins = `CFGMS_MODE_DEFAULT;
    end else if (MULTI_DIE && strap_code == `CFGMS_CODE_SCANONLY) begin
      mode_pins = `CFGMS_CODE_SSERIAL;
    end else begin
      mode_pins = strap_code;
    end
  end

  // device drives the clock wire when enabled, the source drives it otherwise
  assign pin_level = pin_oe ? pin_o : src_clk;
endmodule : cfgms_board_model
`default_nettype wire

// ### verification/config_mode_pin_select_tb.sv
// self-checking bench for the configuration mode pin select block
`timescale 1ns/1ps
`default_nettype none
`include "cfgms_regs.svh"

module config_mode_pin_select_tb;
  // ****************
  // bench
  // ****************
  localparam int HALF  = 3;
  localparam int LIMIT = 20000;
  logic        clk, rstn, strap_en, cfg_start, cfg_done, keep, ext_en, ext_clk, src_clk, fwd, fdata;
  logic        pin_o, pin_oe, pin_lvl, clk_lvl, dout_o, dout_oe, valid, master, scan, b0_en;
  logic [2:0]  strap_code, mode_pins, code;
  logic [1:0]  wsel;
  logic [6:0]  onehot;
  logic [5:0]  lanes;
  logic [4:0]  b0;
  logic [9:0]  b65;
  logic [31:0] rng;
  int          fail_count, checks_done, cycles;

  cfgms_pin_select #(.CLK_HALF(HALF)) i_dut (
    .CLK(clk), .RSTN(rstn), .MODE_PINS(mode_pins), .CFG_START(cfg_start), .WIDTH_SEL(wsel),
    .CFG_DONE(cfg_done), .KEEP_CFG_PINS(keep), .EXT_CLK_EN(ext_en), .EXTERNAL_MASTER_CLOCK_IN(ext_clk),
    .CONFIG_CLOCK_PIN_I(pin_lvl), .CONFIG_CLOCK_PIN_O(pin_o), .CONFIG_CLOCK_PIN_OE(pin_oe),
    .CONFIG_CLOCK_LEVEL(clk_lvl), .DAISY_FWD(fwd), .DAISY_DATA(fdata), .DAISY_OUT_O(dout_o),
    .DAISY_OUT_OE(dout_oe), .MODE_CODE(code), .MODE_ONEHOT(onehot), .MODE_VALID(valid), .IS_MASTER(master),
    .BUS_LANES(lanes), .SCAN_AVAIL(scan), .BANK0_DEDICATED_EN(b0_en), .BANK0_CFG(b0), .BANK65_CFG(b65)
  );

  cfgms_board_model i_board (
    .strap_en(strap_en), .strap_code(strap_code), .src_clk(src_clk), .pin_oe(pin_oe), .pin_o(pin_o),
    .mode_pins(mode_pins), .pin_level(pin_lvl)
  );

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : next_rand

  // expected decode: code 011 falls back to scan only
  function automatic logic [9:0] exp_onehot(input logic [2:0] c);
    return 10'h001 << ((c == 3'h3) ? 3'h4 : ((c < 3'h3) ? c : c - 3'h1));
  endfunction : exp_onehot

  function automatic logic [9:0] exp_lanes(input logic [2:0] c, input logic [1:0] w);
    if (c == 3'h1) return 10'h001 << w;
    if (c == 3'h2 || c == 3'h4) return (w == 2'h0) ? 10'h008 : 10'h010;
    if (c == 3'h6) return 10'h008 << w;
    return 10'h001;
  endfunction : exp_lanes

  function automatic logic [9:0] exp_b0(input logic [2:0] c, input logic [1:0] w);
    if (c == 3'h0 || c == 3'h7) return 10'h004;
    if (c == 3'h1) return w[1] ? 10'h01F : 10'h007;
    if (c == 3'h2 || c == 3'h4 || c == 3'h6) return 10'h01F;
    return 10'h000;
  endfunction : exp_b0

  function automatic logic [9:0] exp_b65(input logic [2:0] c, input logic [1:0] w);
    case (c)
      3'h0: return 10'h050;
      3'h1: return (w == 2'h0) ? 10'h050 : ((w == 2'h3) ? 10'h111 : 10'h010);
      3'h2: return (w == 2'h0) ? 10'h3FD : 10'h3FF;
      3'h4: return (w == 2'h0) ? 10'h071 : 10'h073;
      3'h6: return (w == 2'h0) ? 10'h061 : ((w == 2'h1) ? 10'h063 : 10'h067);
      3'h7: return 10'h040;
      default: return 10'h000;
    endcase
  endfunction : exp_b65

  task automatic count_toggles(output int n);
    logic last;
    n = 0;
    last = pin_o;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (pin_o !== last) n++;
      last = pin_o;
    end
  endtask : count_toggles

  // one reset, capture, clock, daisy and done pass for a strap setting
  task automatic run_case(input logic [2:0] c, input logic [1:0] w, input logic pulled, input logic k,
                          input logic d);
    logic [2:0] e;
    logic       m;
    logic       dm;
    int         n;
    e = pulled ? `CFGMS_MODE_DEFAULT : c;
    m = e inside {3'h0, 3'h1, 3'h2, 3'h4};
    dm = e == 3'h0 || e == 3'h7 || (e == 3'h1 && w == 2'h0);
    @(posedge clk);
    rstn <= 1'b0;
    strap_en <= !pulled;
    strap_code <= c;
    wsel <= w;
    cfg_done <= 1'b0;
    keep <= k;
    ext_en <= 1'b1;
    ext_clk <= 1'b1;
    src_clk <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(10'(valid), 10'h000, "valid before start");
    check(10'({scan, b0_en}), 10'h003, "scan and bank0 on");
    @(posedge clk);
    cfg_start <= 1'b1;
    @(posedge clk);
    cfg_start <= 1'b0;
    strap_code <= ~c;
    repeat (4) @(posedge clk);
    cfg_start <= 1'b1;
    @(posedge clk);
    cfg_start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(10'(code), 10'(e), "captured code");
    check(10'(onehot), exp_onehot(e), "onehot");
    check(10'({valid, master}), {8'h00, 1'b1, m}, "valid and master");
    check(10'(lanes), exp_lanes(e, w), "bus lanes");
    check(10'(pin_oe), 10'(m), "clock pin drive");
    check(10'(b0), exp_b0(e, w), "bank0 use");
    check(b65, exp_b65(e, w), "bank65 use");
    count_toggles(n);
    if (m) check(10'(n), 10'h000, "external clock held");
    check(10'(clk_lvl), 10'h001, "clock level high");
    @(posedge clk);
    ext_clk <= 1'b0;
    src_clk <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(10'(clk_lvl), 10'h000, "clock level low");
    @(posedge clk);
    ext_en <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    count_toggles(n);
    if (m) check(10'(n), 10'(12 / HALF), "internal clock toggles");
    @(posedge clk);
    fwd <= 1'b1;
    fdata <= d;
    @(posedge clk);
    #1;
    check(10'(dout_oe), 10'(dm), "daisy drive");
    if (dm) check(10'(dout_o), 10'(d), "daisy data");
    @(posedge clk);
    fwd <= 1'b0;
    cfg_done <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(10'(dout_oe), 10'h000, "daisy released");
    check(10'(b0), 10'h000, "bank0 after done");
    check(b65, k ? exp_b65(e, w) : 10'h000, "bank65 after done");
  endtask : run_case

  // main sequence: every code and width except width 3 on code 6, floating straps, then random cases
  initial begin
    logic [31:0] r;
    logic [1:0]  w;
    {rstn, strap_en, cfg_start, cfg_done, keep, ext_en, ext_clk, src_clk, fwd, fdata} = 10'h000;
    strap_code = 3'h0;
    wsel = 2'h0;
    rng = 32'h000134F5;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      w = (i / 4 == 6 && i % 4 == 3) ? 2'h2 : 2'(i % 4);
      run_case(3'(i / 4), w, 1'b0, i[0], i[1]);
    end
    run_case(3'h0, 2'h0, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      r = next_rand();
      w = (r[2:0] == 3'h6 && r[4:3] == 2'h3) ? 2'h2 : r[4:3];
      run_case(r[2:0], w, 1'b0, r[5], r[6]);
    end
    finish_test();
  end
endmodule : config_mode_pin_select_tb
`default_nettype wire
